// >>> mcd_defines.svh
// Offsets, field positions, reset values and widths of the main clock divider and gating block.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef MCD_DEFINES_SVH
`define MCD_DEFINES_SVH

`define MCD_OFF_CPU_DIVISION_REGISTER      8'h04
`define MCD_OFF_AHB_CLOCK_GATE_MASK     8'h10
`define MCD_OFF_STATUS      8'h20
`define MCD_OFF_IRQMASK     8'h24

`define MCD_DIV_W           8
`define MCD_CPU_DIVISION_REGISTER_RST      8'h01
`define MCD_GATE_W          13
`define MCD_AHB_CLOCK_GATE_MASK_RST     13'h1FFF
`define MCD_TRUSTED_RAM_BIT        12

`define MCD_ST_W            2
`define MCD_ST_VIOL         0
`define MCD_ST_APPLY        1
`define MCD_ST_RST          2'h0
`define MCD_IRQMASK_RST     2'h0

`define MCD_HTRANS_NONSEQ   2'h2
`define MCD_HRESP_OKAY      1'h0

`endif

// >>> mcd_pkg.sv
// Types shared by the main clock divider and gating block.
// Assumes the AHB-Lite signal set of a single-slave bus.
package mcd_pkg;

  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } mcd_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } mcd_ahb_rsp_t;

  typedef enum logic [1:0] {
    MCD_BUS_IDLE = 2'b00,
    MCD_BUS_WR   = 2'b01,
    MCD_BUS_RDW  = 2'b10,
    MCD_BUS_RDD  = 2'b11
  } mcd_bus_st_t;

endpackage

// >>> mcd_top.sv
// Main clock controller slice: CPU-domain prescaler and AHB client clock gating behind an AHB-Lite slave.
// Assumes one clock; derived clocks leave as one-cycle enable pulses that the clients qualify their clock with.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
`include "mcd_defines.svh"

// How it works
// - Always enabled, no local reset or enable
// - Prescaler division setting is eight bits wide
// - After reset, division one: undivided clock
// - CPU clock rate is main rate over division
// - Forbidden value stored, not used, violation flagged
// - Division writable while everything keeps running
// - New division hits all domain enables together
// - Trusted RAM gate bit low stops clock
// - Trusted RAM gate bit high runs clock
module mcd_top (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  input  wire mcd_pkg::mcd_ahb_req_t ahb_in,
  output mcd_pkg::mcd_ahb_rsp_t      ahb_out,
  output logic                       cpu_clk_en_out,
  output logic [`MCD_GATE_W-1:0]     ahb_clk_en_out,
  output logic                       trusted_ram_clk_en_out,
  output logic                       peripheral_access_guard_viol_out,
  output logic                       irq_out
);
  import mcd_pkg::*;

  // Bus slave state
  mcd_bus_st_t              bus_st_q;
  mcd_bus_st_t              bus_st_d;
  logic [7:0]               addr_q;
  logic [7:0]               addr_d;
  logic [31:0]              hrdata_q;
  logic [31:0]              hrdata_d;
  logic                     accept;

  // Software registers
  logic [`MCD_DIV_W-1:0]    cpu_division_register_q;
  logic [`MCD_DIV_W-1:0]    cpu_division_register_d;
  logic [`MCD_GATE_W-1:0]   ahb_clock_gate_mask_q;
  logic [`MCD_GATE_W-1:0]   ahb_clock_gate_mask_d;
  logic [`MCD_ST_W-1:0]     status_q;
  logic [`MCD_ST_W-1:0]     status_d;
  logic [`MCD_ST_W-1:0]     irqmask_q;
  logic [`MCD_ST_W-1:0]     irqmask_d;
  logic                     viol_q;
  logic                     viol_d;
  logic                     div_wr;
  logic                     div_legal;
  logic [`MCD_ST_W-1:0]     st_set;

  // Prescaler
  logic [`MCD_DIV_W-1:0]    act_div_q;
  logic [`MCD_DIV_W-1:0]    act_div_d;
  logic [`MCD_DIV_W-1:0]    pend_div_q;
  logic [`MCD_DIV_W-1:0]    pend_div_d;
  logic                     pend_q;
  logic                     pend_d;
  logic [`MCD_DIV_W-1:0]    cnt_q;
  logic [`MCD_DIV_W-1:0]    cnt_d;
  logic                     tick_q;
  logic                     tick_d;
  logic [`MCD_GATE_W-1:0]   clken_q;
  logic [`MCD_GATE_W-1:0]   clken_d;
  logic                     wrap;

  // Only powers of two are usable; zero would wrap the counter at 255 and give a 256-cycle period
  function automatic logic div_ok(input logic [`MCD_DIV_W-1:0] v);
    div_ok = (v != '0) && ((v & (v - `MCD_DIV_W'(1))) == '0);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                         input logic [`MCD_DIV_W-1:0] dv,
                                         input logic [`MCD_GATE_W-1:0] gm,
                                         input logic [`MCD_ST_W-1:0] st,
                                         input logic [`MCD_ST_W-1:0] im);
    unique case (a)
      `MCD_OFF_CPU_DIVISION_REGISTER:  rd_mux = 32'(dv);
      `MCD_OFF_AHB_CLOCK_GATE_MASK: rd_mux = 32'(gm);
      `MCD_OFF_STATUS:  rd_mux = 32'(st);
      `MCD_OFF_IRQMASK: rd_mux = 32'(im);
      default:          rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // Bus: writes complete with no wait, reads take one wait state so the data comes from a flop
  assign accept = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

  always_comb begin
    bus_st_d = MCD_BUS_IDLE;
    addr_d   = addr_q;
    hrdata_d = hrdata_q;
    unique case (bus_st_q)
      MCD_BUS_RDW: begin
        bus_st_d = MCD_BUS_RDD;
        hrdata_d = rd_mux(addr_q, cpu_division_register_q, ahb_clock_gate_mask_q, status_q, irqmask_q);
      end
      MCD_BUS_IDLE, MCD_BUS_WR, MCD_BUS_RDD: begin
        if (accept) begin
          bus_st_d = ahb_in.hwrite ? MCD_BUS_WR : MCD_BUS_RDW;
          addr_d   = ahb_in.haddr[7:0];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      bus_st_q <= MCD_BUS_IDLE;
      addr_q   <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      bus_st_q <= bus_st_d;
      addr_q   <= addr_d;
      hrdata_q <= hrdata_d;
    end
  end

  assign ahb_out.hreadyout = (bus_st_q != MCD_BUS_RDW);
  assign ahb_out.hresp     = `MCD_HRESP_OKAY;
  assign ahb_out.hrdata    = hrdata_q;

  // Registers; the division may be rewritten at any time without stopping anything
  assign div_wr    = (bus_st_q == MCD_BUS_WR) && (addr_q == `MCD_OFF_CPU_DIVISION_REGISTER);
  assign div_legal = div_ok(ahb_in.hwdata[`MCD_DIV_W-1:0]);

  always_comb begin
    cpu_division_register_d  = cpu_division_register_q;
    ahb_clock_gate_mask_d = ahb_clock_gate_mask_q;
    irqmask_d = irqmask_q;
    status_d  = status_q;
    viol_d    = 1'b0;
    st_set    = '0;
    st_set[`MCD_ST_VIOL]  = div_wr && !div_legal;
    st_set[`MCD_ST_APPLY] = wrap && pend_q;
    if (bus_st_q == MCD_BUS_WR) begin
      unique case (addr_q)
        `MCD_OFF_CPU_DIVISION_REGISTER: begin
          cpu_division_register_d = ahb_in.hwdata[`MCD_DIV_W-1:0];
          viol_d   = !div_legal;
        end
        // Reserved bits 11:8 are stored as written; software keeps them at one
        `MCD_OFF_AHB_CLOCK_GATE_MASK: ahb_clock_gate_mask_d = ahb_in.hwdata[`MCD_GATE_W-1:0];
        `MCD_OFF_STATUS:  status_d  = status_q & ~ahb_in.hwdata[`MCD_ST_W-1:0];
        `MCD_OFF_IRQMASK: irqmask_d = ahb_in.hwdata[`MCD_ST_W-1:0];
        default: ;
      endcase
    end
    // Set beats a simultaneous write-one-to-clear
    status_d = status_d | st_set;
  end

  // Only the chip reset clears this state; no enable or soft reset exists
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cpu_division_register_q  <= `MCD_CPU_DIVISION_REGISTER_RST;
      ahb_clock_gate_mask_q <= `MCD_AHB_CLOCK_GATE_MASK_RST;
      status_q  <= `MCD_ST_RST;
      irqmask_q <= `MCD_IRQMASK_RST;
      viol_q    <= 1'b0;
    end else begin
      cpu_division_register_q  <= cpu_division_register_d;
      ahb_clock_gate_mask_q <= ahb_clock_gate_mask_d;
      status_q  <= status_d;
      irqmask_q <= irqmask_d;
      viol_q    <= viol_d;
    end
  end

  assign peripheral_access_guard_viol_out = viol_q;
  assign irq_out = |(status_q & irqmask_q);

  // Prescaler: a tick every act_div cycles, so f_cpu = f_main / division
  assign wrap = (cnt_q == `MCD_DIV_W'(act_div_q - `MCD_DIV_W'(1)));

  always_comb begin
    cnt_d      = wrap ? '0 : `MCD_DIV_W'(cnt_q + `MCD_DIV_W'(1));
    act_div_d  = act_div_q;
    pend_div_d = pend_div_q;
    pend_d     = pend_q;
    tick_d     = wrap;
    // Switching only at the period end keeps every period whole
    if (wrap && pend_q) begin
      act_div_d = pend_div_q;
      pend_d    = 1'b0;
    end
    // A forbidden value never reaches the prescaler
    if (div_wr && div_legal) begin
      pend_div_d = ahb_in.hwdata[`MCD_DIV_W-1:0];
      pend_d     = 1'b1;
    end
  end

  // Gate bits are sampled at the period end, so a change never truncates a pulse
  for (genvar i = 0; i < `MCD_GATE_W; i++) begin : g_gate
    assign clken_d[i] = wrap && ahb_clock_gate_mask_q[i];
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      act_div_q  <= `MCD_CPU_DIVISION_REGISTER_RST;
      pend_div_q <= `MCD_CPU_DIVISION_REGISTER_RST;
      pend_q     <= 1'b0;
      cnt_q      <= '0;
      tick_q     <= 1'b0;
      clken_q    <= '0;
    end else begin
      act_div_q  <= act_div_d;
      pend_div_q <= pend_div_d;
      pend_q     <= pend_d;
      cnt_q      <= cnt_d;
      tick_q     <= tick_d;
      clken_q    <= clken_d;
    end
  end

  // One shared counter drives every enable of the domain, so all see a change together
  assign cpu_clk_en_out         = tick_q;
  assign ahb_clk_en_out         = clken_q;
  assign trusted_ram_clk_en_out = clken_q[`MCD_TRUSTED_RAM_BIT];

endmodule // mcd_top

// >>> mcd_checker.sv
// Checker for the clock divider and gating block, bound to mcd_top.
// Assumes the top's AHB-Lite slave ports and one clock domain.
`timescale 1ns/100ps
`include "mcd_defines.svh"
module mcd_checker (
  input wire logic                   core_clk_in,
  input wire logic                   rst_n_in,
  input wire mcd_pkg::mcd_ahb_req_t  ahb_in,
  input wire mcd_pkg::mcd_ahb_rsp_t  ahb_out,
  input wire logic                   cpu_clk_en_out,
  input wire logic [`MCD_GATE_W-1:0] ahb_clk_en_out,
  input wire logic                   trusted_ram_clk_en_out,
  input wire logic                   peripheral_access_guard_viol_out,
  input wire logic                   irq_out
);
  import mcd_pkg::*;
  logic tk;
  logic wdiv;
  assign tk = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
  assign wdiv = tk && ahb_in.hwrite && ahb_in.haddr[7:0] == `MCD_OFF_CPU_DIVISION_REGISTER;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  trusted_ram_map_a: assert property (trusted_ram_clk_en_out == ahb_clk_en_out[`MCD_TRUSTED_RAM_BIT])
    else $error("trusted ram enable differs from its gate");
  gate_sync_a: assert property ((ahb_clk_en_out & ~{`MCD_GATE_W{cpu_clk_en_out}}) == '0)
    else $error("gated enable outside a cpu pulse");
  rd_wait_a: assert property (tk && !ahb_in.hwrite |=> !ahb_out.hreadyout ##1 ahb_out.hreadyout)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (tk && ahb_in.hwrite |=> ahb_out.hreadyout)
    else $error("write stalled");
  resp_ok_a: assert property (ahb_out.hresp == `MCD_HRESP_OKAY)
    else $error("response not okay");
  viol_cause_a: assert property (peripheral_access_guard_viol_out |-> $past(wdiv, 2))
    else $error("violation without a division write");
  rst_full_a: assert property ($rose(rst_n_in) |-> ##[1:2] cpu_clk_en_out [*3])
    else $error("no undivided clock after reset");
  rst_quiet_a: assert property ($rose(rst_n_in) |-> !irq_out && !peripheral_access_guard_viol_out)
    else $error("event outputs active after reset");
  cover property (peripheral_access_guard_viol_out);
  cover property (irq_out);
  cover property (tk && !ahb_in.hwrite);
endmodule // mcd_checker
bind mcd_top mcd_checker i_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ahb_in(ahb_in), .ahb_out(ahb_out),
  .cpu_clk_en_out(cpu_clk_en_out), .ahb_clk_en_out(ahb_clk_en_out), .trusted_ram_clk_en_out(trusted_ram_clk_en_out),
  .peripheral_access_guard_viol_out(peripheral_access_guard_viol_out), .irq_out(irq_out));

// >>> mcd_clients.sv
// Clock clients: cpu core and trusted ram, each ticking once per enable pulse.
// Assumes enables are one-cycle pulses in the core clock domain.
`timescale 1ns/100ps
module mcd_clients (
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  cpu_en_in,
  input  wire logic  trusted_ram_en_in,
  output logic [15:0] cpu_cnt_out,
  output logic [15:0] trusted_ram_cnt_out
);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cpu_cnt_out <= 16'h0;
      trusted_ram_cnt_out <= 16'h0;
    end else begin
      cpu_cnt_out <= cpu_cnt_out + {15'h0, cpu_en_in};
      trusted_ram_cnt_out <= trusted_ram_cnt_out + {15'h0, trusted_ram_en_in};
    end
  end
endmodule // mcd_clients

// >>> tb_top.sv
// Self-checking bench for the clock divider and gating block.
// Assumes mcd_top, mcd_clients and the bound checker are compiled first.
`timescale 1ns/100ps
module tb_top;
  import mcd_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mcd_row_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic vseen = 1'h0;
  mcd_ahb_req_t m = '0;
  mcd_ahb_rsp_t rsp;
  logic cpu_en, irq, viol, trusted_ram;
  logic [12:0] gate;
  logic [15:0] cc, tc, c0, t0;
  logic [31:0] r;
  int fails = 0;
  int cmp_count = 0;
  int n;
  // Reserved gate bits written as ones, bit 12 cleared, upper bits must read 0
  mcd_row_t rows [7] = '{'{1'h0, 8'h10, 32'h0, 32'h1FFF}, '{1'h0, 8'h04, 32'h0, 32'h1},
    '{1'h0, 8'h20, 32'h0, 32'h0}, '{1'h0, 8'h24, 32'h0, 32'h0}, '{1'h1, 8'h10, 32'hFFFFEFFF, 32'h0FFF},
    '{1'h1, 8'h04, 32'h4, 32'h4}, '{1'h1, 8'h30, 32'hFFFFFFFF, 32'h0}};
  mcd_top i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .ahb_in(mcd_ahb_req_t'({m[71:1], rsp.hreadyout})),
    .ahb_out(rsp), .cpu_clk_en_out(cpu_en), .ahb_clk_en_out(gate), .trusted_ram_clk_en_out(trusted_ram),
    .peripheral_access_guard_viol_out(viol), .irq_out(irq));
  mcd_clients i_cl (.clk_in(clk), .rst_n_in(rst_n), .cpu_en_in(cpu_en), .trusted_ram_en_in(trusted_ram),
    .cpu_cnt_out(cc), .trusted_ram_cnt_out(tc));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (viol) vseen <= 1'h1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    m.hsel <= 1'h1;
    m.htrans <= 2'h2;
    m.haddr <= {24'h0, a};
    m.hwrite <= w;
    m.hsize <= 3'h2;
    do @(posedge clk); while (rsp.hreadyout !== 1'h1);
    m.hsel <= 1'h0;
    m.htrans <= 2'h0;
    m.hwdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'h1);
    q = rsp.hrdata;
  endtask
  // Period in cycles between two cpu pulses
  task automatic per(output int p);
    do @(posedge clk); while (cpu_en !== 1'h1);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (cpu_en !== 1'h1);
  endtask
  task automatic span(input int k);
    repeat (8) @(posedge clk);
    c0 = cc;
    t0 = tc;
    repeat (k) @(posedge clk);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #40000;
    fails++;
    summarize;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'h1, rows[i].a, rows[i].d, r);
      bus(1'h0, rows[i].a, 32'h0, r);
      chk("register", rows[i].e, r);
    end
    $display("register table done");
    span(40);
    chk("cpu pulses", 32'hA, {16'h0, cc - c0});
    chk("trusted_ram gated", 32'h0, {16'h0, tc - t0});
    bus(1'h1, 8'h10, 32'h1FFF, r);
    span(40);
    chk("trusted_ram runs", 32'hA, {16'h0, tc - t0});
    $display("gating done");
    bus(1'h1, 8'h04, 32'h3, r);
    per(n);
    per(n);
    chk("kept period", 32'h4, 32'(n));
    bus(1'h0, 8'h04, 32'h0, r);
    chk("stored div", 32'h3, r);
    chk("violation", 32'h1, {31'h0, vseen});
    bus(1'h1, 8'h24, 32'h1, r);
    repeat (2) @(posedge clk);
    chk("irq set", 32'h1, {31'h0, irq});
    bus(1'h1, 8'h20, 32'h1, r);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("forbidden value done");
    bus(1'h1, 8'h04, 32'h80, r);
    per(n);
    per(n);
    chk("period 128", 32'h80, 32'(n));
    bus(1'h0, 8'h20, 32'h0, r);
    chk("apply flag", 32'h2, r);
    rst_n <= 1'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    per(n);
    per(n);
    chk("reset period", 32'h1, 32'(n));
    $display("reset done");
    summarize;
  end
endmodule // tb_top
